/* core/dpr_regs.sv */
// How it works
// RL1: page c0 decodes as peripheral register space
// RL2: host control registers mirrored at c000..c00f
// RL3: c010 shows last host control access, write flag
// RL4: c011 returns last two serial bytes
// RL5: every fourth cycle add increment to accumulator
// RL6: overflow latches samples and raises DAC interrupt
// RL7: direction bit one makes pin output
// RL8: output levels kept when direction goes input
// RL9: c018 reads synchronised pin levels
// RL10: pins never raise any interrupt
// RL11: host memory window reaches same registers
// RL12: mask bits gate sources by position
// RL13: mask and counter writes act within six cycles
// RL14: block-increment write adds one to counter
// RL15: block-decrement write subtracts, floor at zero
// RL16: interrupts pass only while counter is zero
// RL17: taken interrupt adds one to counter
// RL18: service routine ends writing block-decrement register
// RL19: nesting counter is readable
// RL20: accumulator wraps and keeps remainder
// RL21: all registers and accumulator reset to zero
`timescale 1ns/10ps
`default_nettype none

module dpr_regs
	import dpr_pkg::*;
(
	// clock and reset
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 RST_I,
	// core data bus
	input  wire logic [15:0]          CORE_ADDR_I,
	input  wire logic                 CORE_WR_I,
	input  wire logic                 CORE_RD_I,
	input  wire logic [15:0]          CORE_WDATA_I,
	output logic      [15:0]          CORE_RDATA_O,
	output logic                      CORE_RVALID_O,
	input  wire logic                 CORE_IRQ_TAKEN_I,
	// host control port
	input  wire logic                 CTL_WR_I,
	input  wire logic                 CTL_RD_I,
	input  wire logic [3:0]           CTL_IDX_I,
	input  wire logic [15:0]          CTL_WDATA_I,
	output logic      [15:0]          CTL_RDATA_O,
	// host memory pointer and window
	input  wire logic [15:0]          HOST_MEMORY_POINTER_I,
	input  wire logic                 HOST_MEMORY_WINDOW_WR_I,
	input  wire logic                 HOST_MEMORY_WINDOW_RD_I,
	input  wire logic [15:0]          HOST_MEMORY_WINDOW_WDATA_I,
	output logic      [15:0]          HOST_MEMORY_WINDOW_RDATA_O,
	output logic                      HOST_MEMORY_WINDOW_ACK_O,
	// serial data input
	input  wire logic                 STREAM_INPUT_PORT_VALID_I,
	input  wire logic [7:0]           STREAM_INPUT_PORT_BYTE_I,
	output logic                      REQUEST_PIN_O,
	// converter
	output logic      [15:0]          DAC_LEFT_O,
	output logic      [15:0]          DAC_RIGHT_O,
	output logic                      DAC_LOAD_O,
	// general-purpose pins
	input  wire logic [GPIO_BITS-1:0] GPIO_PIN_I,
	output logic      [GPIO_BITS-1:0] GPIO_PIN_O,
	output logic      [GPIO_BITS-1:0] GPIO_PIN_OE_O,
	// interrupts
	input  wire logic [7:0]           IRQ_SRC_I,
	output logic      [7:0]           IRQ_REQ_O
);

	logic [15:0]          ctl_regs [DPR_CTL_REGS];
	logic                 last_access_was_write;
	logic [3:0]           last_access_index;
	logic [15:0]          serial_input_word;
	logic [15:0]          sample_rate_low;
	logic [15:0]          sample_rate_high_pll;
	logic [15:0]          left_channel_sample;
	logic [15:0]          right_channel_sample;
	logic [GPIO_BITS-1:0] pin_direction;
	logic [GPIO_BITS-1:0] pin_output_level;
	logic [GPIO_BITS-1:0] pin_meta;
	logic [GPIO_BITS-1:0] pin_input_value;
	logic [7:0]           irq_enable_mask;
	logic [NEST_BITS-1:0] irq_nest_count;
	logic [ACC_BITS-1:0]  rate_acc;
	logic [1:0]           tick_div;

	// core has priority; a host window request waits while the core uses the bus
	// a request still held in its acknowledge cycle is not taken a second time
	wire         core_act = CORE_WR_I | CORE_RD_I;
	wire         host_req = HOST_MEMORY_WINDOW_WR_I | HOST_MEMORY_WINDOW_RD_I;
	wire         host_go  = host_req & ~core_act & ~HOST_MEMORY_WINDOW_ACK_O; // RL11
	dpr_access_t acc_s;
	assign acc_s = core_act ?
		dpr_access_t'{wr: CORE_WR_I, rd: CORE_RD_I, addr: CORE_ADDR_I, wdata: CORE_WDATA_I} :
		dpr_access_t'{wr: host_go & HOST_MEMORY_WINDOW_WR_I,
		  rd: host_go & HOST_MEMORY_WINDOW_RD_I,
		  addr: HOST_MEMORY_POINTER_I, wdata: HOST_MEMORY_WINDOW_WDATA_I}; // RL11

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	wire in_win   = (acc_s.addr[15:8] == DPR_WIN_PAGE); // RL1
	wire ctl_hit  = in_win && (acc_s.addr <= DPR_CTL_LAST); // RL2
	wire wr_en    = acc_s.wr & in_win;
	wire rd_en    = acc_s.rd & in_win;
	wire [3:0] ctl_widx = acc_s.addr[3:0];

	wire wr_reqpin = wr_en && hit(acc_s.addr, DPR_REQ_PIN_CTL);
	wire wr_rlow   = wr_en && hit(acc_s.addr, DPR_RATE_LOW);
	wire wr_rhigh  = wr_en && hit(acc_s.addr, DPR_RATE_HIGH);
	wire wr_left   = wr_en && hit(acc_s.addr, DPR_LEFT_SAMPLE);
	wire wr_right  = wr_en && hit(acc_s.addr, DPR_RIGHT_SAMPLE);
	wire wr_dir    = wr_en && hit(acc_s.addr, DPR_PIN_DIR);
	wire wr_pout   = wr_en && hit(acc_s.addr, DPR_PIN_OUT);
	wire wr_mask   = wr_en && hit(acc_s.addr, DPR_IRQ_MASK);
	wire wr_blkinc = wr_en && hit(acc_s.addr, DPR_IRQ_BLK_INC);
	wire wr_blkdec = wr_en && hit(acc_s.addr, DPR_IRQ_BLK_DEC);
	wire wr_nest   = wr_en && hit(acc_s.addr, DPR_IRQ_NEST);

	// read mux; unmapped and write-only offsets read as zero
	logic [15:0] rd_word;
	always_comb begin
		rd_word = DPR_RESET_WORD;
		if (ctl_hit) begin
			rd_word = ctl_regs[ctl_widx]; // RL2
		end else begin
			case (acc_s.addr)
				DPR_LAST_CTL_ACC: rd_word = {11'h000, last_access_was_write, last_access_index}; // RL3
				DPR_SERIAL_WORD:  rd_word = serial_input_word; // RL4
				DPR_RATE_LOW:     rd_word = sample_rate_low;
				DPR_RATE_HIGH:    rd_word = sample_rate_high_pll;
				DPR_LEFT_SAMPLE:  rd_word = left_channel_sample;
				DPR_RIGHT_SAMPLE: rd_word = right_channel_sample;
				DPR_PIN_DIR:      rd_word = {8'h00, pin_direction};
				DPR_PIN_IN:       rd_word = {8'h00, pin_input_value}; // RL9
				DPR_PIN_OUT:      rd_word = {8'h00, pin_output_level};
				DPR_IRQ_MASK:     rd_word = {8'h00, irq_enable_mask};
				DPR_IRQ_NEST:     rd_word = {11'h000, irq_nest_count}; // RL19
				default:          rd_word = DPR_RESET_WORD;
			endcase
		end
	end

	// bus answers one cycle after the access
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			CORE_RDATA_O               <= 16'h0000;
			CORE_RVALID_O              <= 1'b0;
			HOST_MEMORY_WINDOW_RDATA_O <= 16'h0000;
			HOST_MEMORY_WINDOW_ACK_O   <= 1'b0;
		end else begin
			CORE_RVALID_O            <= CORE_RD_I & in_win;
			HOST_MEMORY_WINDOW_ACK_O <= host_go;
			if (CORE_RD_I)
				CORE_RDATA_O <= rd_word;
			if (host_go && HOST_MEMORY_WINDOW_RD_I)
				HOST_MEMORY_WINDOW_RDATA_O <= rd_word; // RL11
		end
	end

	// control-port mirror; a host port write wins a same-cycle clash on one index
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < DPR_CTL_REGS; i++)
				ctl_regs[i] <= 16'h0000; // RL21
			CTL_RDATA_O           <= 16'h0000;
			last_access_was_write <= 1'b0;
			last_access_index     <= 4'h0;
		end else begin
			if (wr_en && ctl_hit)
				ctl_regs[ctl_widx] <= acc_s.wdata; // RL2
			if (CTL_WR_I)
				ctl_regs[CTL_IDX_I] <= CTL_WDATA_I;
			if (CTL_RD_I)
				CTL_RDATA_O <= ctl_regs[CTL_IDX_I];
			if (CTL_WR_I || CTL_RD_I) begin
				last_access_was_write <= CTL_WR_I; // RL3
				last_access_index     <= CTL_IDX_I; // RL3
			end
		end
	end

	// serial word and request pin
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			serial_input_word <= 16'h0000;
			REQUEST_PIN_O     <= 1'b0;
		end else begin
			if (STREAM_INPUT_PORT_VALID_I)
				serial_input_word <= {serial_input_word[7:0], STREAM_INPUT_PORT_BYTE_I}; // RL4
			if (wr_reqpin)
				REQUEST_PIN_O <= acc_s.wdata[0];
		end
	end

	// sample-rate accumulator; one extra bit catches the carry
	wire [ACC_BITS-1:0] rate_inc = {6'h00, sample_rate_high_pll[RATE_HI_BITS-1:0],
		sample_rate_low}; // RL5
	wire [ACC_BITS:0]   acc_sum  = {1'b0, rate_acc} + {1'b0, rate_inc};
	wire                tick     = (tick_div == 2'(DAC_TICK_CYCLES - 1));
	wire                dac_ovf  = tick & acc_sum[ACC_BITS]; // RL6

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			tick_div             <= 2'h0;
			rate_acc             <= 26'h0000000; // RL21
			sample_rate_low      <= 16'h0000;
			sample_rate_high_pll <= 16'h0000;
			left_channel_sample  <= 16'h0000;
			right_channel_sample <= 16'h0000;
			DAC_LEFT_O           <= 16'h0000;
			DAC_RIGHT_O          <= 16'h0000;
			DAC_LOAD_O           <= 1'b0;
		end else begin
			tick_div <= tick_div + 2'h1; // RL5
			if (tick)
				rate_acc <= acc_sum[ACC_BITS-1:0]; // RL20
			if (wr_rlow)
				sample_rate_low <= acc_s.wdata;
			if (wr_rhigh)
				sample_rate_high_pll <= acc_s.wdata;
			if (wr_left)
				left_channel_sample <= acc_s.wdata;
			if (wr_right)
				right_channel_sample <= acc_s.wdata;
			DAC_LOAD_O <= dac_ovf;
			if (dac_ovf) begin
				DAC_LEFT_O  <= left_channel_sample; // RL6
				DAC_RIGHT_O <= right_channel_sample; // RL6
			end
		end
	end

	// pins; direction changes never touch the stored output levels
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pin_direction    <= 8'h00;
			pin_output_level <= 8'h00;
			pin_meta         <= 8'h00;
			pin_input_value  <= 8'h00;
			GPIO_PIN_O       <= 8'h00;
			GPIO_PIN_OE_O    <= 8'h00;
		end else begin
			pin_meta        <= GPIO_PIN_I;
			pin_input_value <= pin_meta; // RL9
			if (wr_dir)
				pin_direction <= acc_s.wdata[GPIO_BITS-1:0];
			if (wr_pout)
				pin_output_level <= acc_s.wdata[GPIO_BITS-1:0]; // RL8
			GPIO_PIN_O    <= pin_output_level;
			GPIO_PIN_OE_O <= pin_direction; // RL7
		end
	end

	// nesting counter: increments stack, the decrement floors at zero, top saturates
	wire [1:0] n_inc = {1'b0, wr_blkinc} + {1'b0, CORE_IRQ_TAKEN_I}; // RL14 RL17
	wire [6:0] n_up  = {2'b00, irq_nest_count} + {5'h00, n_inc};
	wire [6:0] n_dn  = (wr_blkdec && n_up != 7'h00) ? n_up - 7'h01 : n_up; // RL15
	logic [NEST_BITS-1:0] next_nest;
	assign next_nest = wr_nest ? acc_s.wdata[NEST_BITS-1:0] :
		(n_dn > 7'h1f) ? 5'h1f : n_dn[NEST_BITS-1:0];

	// pins feed no source: bit 0 is the converter, bit 3 stays empty
	wire [7:0] irq_src = ({IRQ_SRC_I[7:1], 1'b0} | {7'h00, dac_ovf}) & IRQ_USED_MASK; // RL10 RL12

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			irq_enable_mask <= 8'h00;
			irq_nest_count  <= 5'h00;
			IRQ_REQ_O       <= 8'h00;
		end else begin
			if (wr_mask)
				irq_enable_mask <= acc_s.wdata[7:0];
			irq_nest_count <= next_nest; // RL14 RL15 RL17
			// one register stage keeps the write-to-effect delay well inside the limit
			IRQ_REQ_O <= (irq_nest_count == 5'h00) ? (irq_src & irq_enable_mask) : 8'h00; // RL12 RL13 RL16
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	AST_ACC_STEP: assert property ( // RL5
		tick |=> rate_acc == 26'($past(rate_acc) + $past(rate_inc)))
		else $error("accumulator did not add increment on tick");

	AST_ACC_HOLD: assert property ( // RL5
		!tick |=> rate_acc == $past(rate_acc))
		else $error("accumulator moved off tick");

	AST_DAC_LATCH: assert property ( // RL6
		dac_ovf |=> DAC_LOAD_O && DAC_LEFT_O == $past(left_channel_sample)
			&& DAC_RIGHT_O == $past(right_channel_sample))
		else $error("samples not latched on overflow");

	AST_SERIAL_WORD: assert property ( // RL4
		STREAM_INPUT_PORT_VALID_I ##1 STREAM_INPUT_PORT_VALID_I |=>
			serial_input_word == {$past(STREAM_INPUT_PORT_BYTE_I, 2), $past(STREAM_INPUT_PORT_BYTE_I)})
		else $error("serial word byte order wrong");

	AST_LAST_ACCESS: assert property ( // RL3
		CTL_WR_I |=> last_access_was_write && last_access_index == $past(CTL_IDX_I))
		else $error("last access tracker wrong");

	AST_PIN_IN: assert property ( // RL9
		##2 pin_input_value == $past(GPIO_PIN_I, 2))
		else $error("pin input not two stages behind pins");

	AST_OE_DIR: assert property ( // RL7
		wr_dir |=> ##1 GPIO_PIN_OE_O == $past(acc_s.wdata[7:0], 2))
		else $error("output enable does not follow direction");

	AST_OUT_KEEP: assert property ( // RL8
		wr_dir && !wr_pout |=> pin_output_level == $past(pin_output_level))
		else $error("output levels changed by direction write");

	AST_NEST_INC: assert property ( // RL14
		wr_blkinc && !wr_nest && !wr_blkdec && !CORE_IRQ_TAKEN_I && irq_nest_count != 5'h1f
			|=> irq_nest_count == $past(irq_nest_count) + 5'h01)
		else $error("block increment did not add one");

	AST_NEST_FLOOR: assert property ( // RL15
		wr_blkdec && !wr_nest && !CORE_IRQ_TAKEN_I && irq_nest_count == 5'h00
			|=> irq_nest_count == 5'h00)
		else $error("counter went below zero");

	AST_TAKEN_INC: assert property ( // RL17
		CORE_IRQ_TAKEN_I && !wr_en && irq_nest_count != 5'h1f
			|=> irq_nest_count == $past(irq_nest_count) + 5'h01)
		else $error("taken interrupt did not add one");

	AST_IRQ_BLOCKED: assert property ( // RL16
		irq_nest_count != 5'h00 |=> IRQ_REQ_O == 8'h00)
		else $error("interrupt passed while blocked");

	AST_IRQ_MASK: assert property ( // RL12
		1'b1 |=> (IRQ_REQ_O & ~$past(irq_enable_mask)) == 8'h00 && !IRQ_REQ_O[3])
		else $error("masked source reached request");

	AST_HOST_ACK: assert property ( // RL11
		host_req && !core_act && !HOST_MEMORY_WINDOW_ACK_O |=> HOST_MEMORY_WINDOW_ACK_O)
		else $error("host window request not acknowledged");

	AST_WIN_VALID: assert property ( // RL1
		CORE_RD_I |=> CORE_RVALID_O == ($past(CORE_ADDR_I[15:8]) == DPR_WIN_PAGE))
		else $error("read valid does not follow window decode");

	AST_OUT_WIN_ZERO: assert property ( // RL1
		CORE_RD_I && CORE_ADDR_I[15:8] != DPR_WIN_PAGE |=> CORE_RDATA_O == 16'h0000)
		else $error("read outside window returned data");

	AST_CTL_MIRROR: assert property ( // RL2
		CORE_RD_I && CORE_ADDR_I >= DPR_CTL_FIRST && CORE_ADDR_I <= DPR_CTL_LAST
			|=> CORE_RDATA_O == $past(ctl_regs[CORE_ADDR_I[3:0]]))
		else $error("control mirror read wrong");

	AST_LAST_READ: assert property ( // RL3
		CTL_RD_I && !CTL_WR_I
			|=> !last_access_was_write && last_access_index == $past(CTL_IDX_I))
		else $error("last access tracker missed a read");

	AST_TICK_PERIOD: assert property ( // RL5
		tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
		else $error("accumulator tick not every fourth cycle");

	AST_DAC_IRQ: assert property ( // RL6
		dac_ovf && irq_enable_mask[IRQ_DAC] && irq_nest_count == 5'h00
			|=> IRQ_REQ_O[IRQ_DAC])
		else $error("overflow raised no converter request");

	AST_PIN_OUT: assert property ( // RL7
		1'b1 |=> GPIO_PIN_O == $past(pin_output_level))
		else $error("pin levels do not follow output register");

	AST_NEST_DEC: assert property ( // RL15
		wr_blkdec && !wr_nest && !CORE_IRQ_TAKEN_I && irq_nest_count != 5'h00
			|=> irq_nest_count == $past(irq_nest_count) - 5'h01)
		else $error("block decrement did not subtract one");

	AST_IRQ_PASS: assert property ( // RL16
		irq_nest_count == 5'h00 |=> IRQ_REQ_O[7:1] ==
			($past(IRQ_SRC_I[7:1]) & $past(irq_enable_mask[7:1]) & IRQ_USED_MASK[7:1]))
		else $error("enabled source not delivered at zero count");

endmodule : dpr_regs

`default_nettype wire

/* include/dpr_pkg.sv */
package dpr_pkg;

	// peripheral window on the core's X-data bus
	localparam logic [7:0]  DPR_WIN_PAGE     = 8'hc0;
	localparam logic [15:0] DPR_CTL_FIRST    = 16'hc000;
	localparam logic [15:0] DPR_CTL_LAST     = 16'hc00f;
	localparam int          DPR_CTL_REGS     = 16;

	// register offsets
	localparam logic [15:0] DPR_LAST_CTL_ACC = 16'hc010;
	localparam logic [15:0] DPR_SERIAL_WORD  = 16'hc011;
	localparam logic [15:0] DPR_REQ_PIN_CTL  = 16'hc012;
	localparam logic [15:0] DPR_RATE_LOW     = 16'hc013;
	localparam logic [15:0] DPR_RATE_HIGH    = 16'hc014;
	localparam logic [15:0] DPR_LEFT_SAMPLE  = 16'hc015;
	localparam logic [15:0] DPR_RIGHT_SAMPLE = 16'hc016;
	localparam logic [15:0] DPR_PIN_DIR      = 16'hc017;
	localparam logic [15:0] DPR_PIN_IN       = 16'hc018;
	localparam logic [15:0] DPR_PIN_OUT      = 16'hc019;
	localparam logic [15:0] DPR_IRQ_MASK     = 16'hc01a;
	localparam logic [15:0] DPR_IRQ_BLK_INC  = 16'hc01b;
	localparam logic [15:0] DPR_IRQ_BLK_DEC  = 16'hc01c;
	localparam logic [15:0] DPR_IRQ_NEST     = 16'hc01d;

	// field layouts
	localparam int LCA_WRITE_BIT  = 4;
	localparam int RATE_HI_BITS   = 4;
	localparam int ACC_BITS       = 26;
	localparam int NEST_BITS      = 5;
	localparam int GPIO_BITS      = 8;

	// interrupt source positions
	localparam int IRQ_TIMER1     = 7;
	localparam int IRQ_TIMER0     = 6;
	localparam int IRQ_UART_RX    = 5;
	localparam int IRQ_UART_TX    = 4;
	localparam int IRQ_DATA_PORT  = 2;
	localparam int IRQ_CTL_PORT   = 1;
	localparam int IRQ_DAC        = 0;
	localparam logic [7:0] IRQ_USED_MASK = 8'hf7;

	// timing
	localparam int DAC_TICK_CYCLES = 4;
	localparam int IRQ_LATENCY_MAX = 6;

	// reset values
	localparam logic [15:0] DPR_RESET_WORD = 16'h0000;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dpr_access_t;

endpackage : dpr_pkg

/* verif/dpr_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module dpr_core_model
	import dpr_pkg::*;
(
	// clock and interrupt requests
	input  wire logic        clk_sys_i,
	input  wire logic [7:0]  irq_req_i,
	// data bus master
	output logic      [15:0] core_addr_o,
	output logic             core_wr_o,
	output logic             core_rd_o,
	output logic      [15:0] core_wdata_o,
	output logic             core_irq_taken_o
);
	logic take_en = 1'b0;
	logic armed = 1'b1;
	int   take_delay = 0;

	initial begin
		core_addr_o = 16'h0000;
		{core_wr_o, core_rd_o, core_irq_taken_o} = 3'b000;
		core_wdata_o = 16'h0000;
	end

	// one-cycle strobe per access, as the core issues them
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] v);
		@(posedge clk_sys_i);
		core_wr_o <= w;
		core_rd_o <= ~w;
		core_addr_o <= a;
		core_wdata_o <= v;
		@(posedge clk_sys_i);
		{core_wr_o, core_rd_o} <= 2'b00;
		// released bus shows inverted values so nothing stale looks valid
		core_addr_o <= ~a;
		core_wdata_o <= ~v;
	endtask : acc

	// takes one interrupt per request, promptly or after take_delay cycles
	always @(posedge clk_sys_i) begin
		core_irq_taken_o <= 1'b0;
		if (take_en && armed && irq_req_i != 8'h00) begin
			armed <= 1'b0;
			repeat (take_delay) @(posedge clk_sys_i);
			core_irq_taken_o <= 1'b1;
		end else if (irq_req_i == 8'h00) begin
			armed <= 1'b1;
		end
	end
endmodule : dpr_core_model

`default_nettype wire

/* verif/dpr_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module dpr_regs_tb_top;
	import dpr_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] core_addr, core_wdata, core_rdata, ctl_wdata, ctl_rdata, d;
	logic [15:0] hm_ptr, hm_wdata, hm_rdata, dac_l, dac_r, q_core[$];
	logic        core_wr, core_rd, core_rvalid, irq_taken, ctl_wr, ctl_rd, hm_wr, hm_rd;
	logic        hm_ack, sp_valid, req_pin, dac_load;
	logic [3:0]  ctl_idx;
	logic [7:0]  sp_byte, pin_i, pin_o, pin_oe, irq_src, irq_req, pv;
	logic [16:0] eh, q_host[$];
	logic [31:0] seed = 32'h00015501;
	int          fail_count = 0, n_checks = 0, cyc = 0, t[4], k;

	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	dpr_regs i_dpr_regs (.CLK_SYS_I(clk), .RST_I(rst), .CORE_ADDR_I(core_addr),
		.CORE_WR_I(core_wr), .CORE_RD_I(core_rd), .CORE_WDATA_I(core_wdata),
		.CORE_RDATA_O(core_rdata), .CORE_RVALID_O(core_rvalid), .CORE_IRQ_TAKEN_I(irq_taken),
		.CTL_WR_I(ctl_wr), .CTL_RD_I(ctl_rd), .CTL_IDX_I(ctl_idx), .CTL_WDATA_I(ctl_wdata),
		.CTL_RDATA_O(ctl_rdata), .HOST_MEMORY_POINTER_I(hm_ptr),
		.HOST_MEMORY_WINDOW_WR_I(hm_wr), .HOST_MEMORY_WINDOW_RD_I(hm_rd),
		.HOST_MEMORY_WINDOW_WDATA_I(hm_wdata), .HOST_MEMORY_WINDOW_RDATA_O(hm_rdata),
		.HOST_MEMORY_WINDOW_ACK_O(hm_ack), .STREAM_INPUT_PORT_VALID_I(sp_valid),
		.STREAM_INPUT_PORT_BYTE_I(sp_byte), .REQUEST_PIN_O(req_pin), .DAC_LEFT_O(dac_l),
		.DAC_RIGHT_O(dac_r), .DAC_LOAD_O(dac_load), .GPIO_PIN_I(pin_i), .GPIO_PIN_O(pin_o),
		.GPIO_PIN_OE_O(pin_oe), .IRQ_SRC_I(irq_src), .IRQ_REQ_O(irq_req));

	dpr_core_model i_dpr_core_model (.clk_sys_i(clk), .irq_req_i(irq_req),
		.core_addr_o(core_addr), .core_wr_o(core_wr), .core_rd_o(core_rd),
		.core_wdata_o(core_wdata), .core_irq_taken_o(irq_taken));

	// xorshift seeded with 87297
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : xs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bad();
		fail_count++;
		$display("ERROR %0t answer missing or unexpected", $time);
	endtask : bad

	task automatic final_report();
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		q_core.push_back(e);
		i_dpr_core_model.acc(1'b0, a, 16'h0000);
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		i_dpr_core_model.acc(1'b1, a, v);
	endtask : wr

	// request stands until the edge at which the acknowledge is seen high
	task automatic hw(input logic w, input logic [15:0] a, input logic [15:0] v);
		int n;
		q_host.push_back({~w, v});
		@(posedge clk);
		{hm_wr, hm_rd} <= {w, ~w};
		hm_ptr <= a;
		hm_wdata <= v;
		@(posedge clk);
		for (n = 0; n < 8 && hm_ack !== 1'b1; n++) @(posedge clk);
		{hm_wr, hm_rd} <= 2'b00;
		hm_ptr <= ~a;
		if (n == 8) begin
			bad();
			final_report();
		end
	endtask : hw

	task automatic ctl(input logic w, input logic [3:0] i, input logic [15:0] v);
		@(posedge clk);
		{ctl_wr, ctl_rd} <= {w, ~w};
		ctl_idx <= i;
		ctl_wdata <= v;
		@(posedge clk);
		{ctl_wr, ctl_rd} <= 2'b00;
		ctl_wdata <= ~v;
		@(negedge clk);
	endtask : ctl

	task automatic irq_is(input logic [7:0] e);
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({8'h00, irq_req}, {8'h00, e});
	endtask : irq_is

	task automatic wait_load(output int at);
		int n;
		@(posedge clk);
		for (n = 0; n < 400 && dac_load !== 1'b1; n++) @(posedge clk);
		at = cyc;
		if (n == 400) begin
			bad();
			final_report();
		end
	endtask : wait_load

	always @(posedge clk) begin
		if (core_rvalid === 1'b1) begin
			if (q_core.size() == 0) bad();
			else chk(core_rdata, q_core.pop_front());
		end
		if (hm_ack === 1'b1) begin
			if (q_host.size() == 0) bad();
			else begin
				eh = q_host.pop_front();
				if (eh[16]) chk(hm_rdata, eh[15:0]);
			end
		end
	end

	initial begin
		{ctl_wr, ctl_rd, hm_wr, hm_rd, sp_valid} = 5'b00000;
		{ctl_wdata, hm_ptr, hm_wdata} = 48'h0;
		{ctl_idx, sp_byte, pin_i, irq_src} = 28'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (k = 16; k < 30; k++) rd(16'hc000 + 16'(k), 16'h0000);
		rd(16'hc0ff, 16'h0000);
		wr(16'hc100, 16'hffff);
		i_dpr_core_model.acc(1'b0, 16'hc100, 16'h0000);
		i_dpr_core_model.acc(1'b0, 16'hbfff, 16'h0000);
		for (k = 0; k < 16; k += 5) begin
			d = xs();
			ctl(1'b1, 4'(k), d);
			rd(DPR_CTL_FIRST + 16'(k), d);
			rd(DPR_LAST_CTL_ACC, 16'h0010 | 16'(k));
			wr(DPR_CTL_FIRST + 16'(k), ~d);
			ctl(1'b0, 4'(k), 16'h0000);
			chk(ctl_rdata, ~d);
			wr(DPR_LAST_CTL_ACC, 16'hffff);
			rd(DPR_LAST_CTL_ACC, 16'(k));
		end
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			pv = 8'(xs());
			sp_valid <= 1'b1;
			sp_byte <= pv;
			d = {d[7:0], pv};
		end
		@(posedge clk);
		sp_valid <= 1'b0;
		rd(DPR_SERIAL_WORD, d);
		wr(DPR_REQ_PIN_CTL, 16'h0003);
		@(negedge clk);
		chk({15'h0, req_pin}, 16'h0001);
		wr(DPR_IRQ_MASK, 16'h00ff);
		rd(DPR_IRQ_MASK, 16'h00ff);
		wr(DPR_PIN_DIR, 16'h00a5);
		wr(DPR_PIN_OUT, 16'h003c);
		repeat (3) @(negedge clk);
		chk({pin_oe, pin_o}, 16'ha53c);
		wr(DPR_PIN_DIR, 16'h0000);
		rd(DPR_PIN_OUT, 16'h003c);
		repeat (3) @(negedge clk);
		chk({pin_oe, pin_o}, 16'h003c);
		@(posedge clk);
		pv = 8'(xs());
		pin_i <= pv;
		repeat (4) @(posedge clk);
		rd(DPR_PIN_IN, {8'h00, pv});
		irq_is(8'h00);
		irq_src <= 8'hff;
		for (k = 0; k < 8; k++) begin
			wr(DPR_IRQ_MASK, 16'(1 << k));
			irq_is(8'hf6 & 8'(1 << k));
		end
		wr(DPR_IRQ_MASK, 16'h00ff);
		wr(DPR_IRQ_BLK_INC, xs());
		wr(DPR_IRQ_BLK_INC, xs());
		rd(DPR_IRQ_NEST, 16'h0002);
		irq_is(8'h00);
		for (k = 0; k < 3; k++) wr(DPR_IRQ_BLK_DEC, xs());
		rd(DPR_IRQ_NEST, 16'h0000);
		irq_is(8'hf6);
		for (k = 0; k < 2; k++) begin
			i_dpr_core_model.take_delay = 3 * k;
			i_dpr_core_model.take_en = 1'b1;
			repeat (6) @(posedge clk);
			irq_is(8'h00);
			i_dpr_core_model.take_en = 1'b0;
			rd(DPR_IRQ_NEST, 16'h0001);
			wr(DPR_IRQ_BLK_DEC, xs());
			irq_is(8'hf6);
		end
		@(posedge clk);
		irq_src <= 8'h00;
		hw(1'b1, DPR_PIN_DIR, 16'h005a);
		hw(1'b0, DPR_PIN_DIR, 16'h005a);
		hw(1'b0, DPR_IRQ_NEST, 16'h0000);
		repeat (2) @(negedge clk);
		chk({pin_oe, pin_o}, 16'h5a3c);
		wr(DPR_IRQ_MASK, 16'h0001);
		wr(DPR_LEFT_SAMPLE, d);
		wr(DPR_RIGHT_SAMPLE, ~d);
		wr(DPR_RATE_HIGH, 16'habcc);
		rd(DPR_RATE_HIGH, 16'habcc);
		// increment of 0xc0000 overflows every 85.33 ticks: 3 loads span exactly 256 ticks
		for (k = 0; k < 4; k++) begin
			wait_load(t[k]);
			chk(dac_l, d);
			chk(dac_r, ~d);
			// the request pulse stands only in the cycle of the load pulse
			chk({15'h0, irq_req[0]}, 16'h0001);
		end
		chk(16'(t[3] - t[0]), 16'h0400);
		repeat (4) @(posedge clk);
		if (q_core.size() != 0 || q_host.size() != 0) bad();
		final_report();
	end
endmodule : dpr_regs_tb_top

`default_nettype wire
